// ### rtl/ctz_pkg.sv
// Package of constants and types for the charger temperature zone monitor
package ctz_pkg;

    // Register offsets on the plain register port
    localparam logic [3:0] threshold_config_offset        = 4'h0;
    localparam logic [3:0] thermistor_config_offset       = 4'h1;
    localparam logic [3:0] voltage_config_offset          = 4'h2;
    localparam logic [3:0] modified_voltage_config_offset = 4'h3;
    localparam logic [3:0] charger_status_offset          = 4'h4;
    localparam logic [3:0] charger_irq_offset             = 4'h5;
    localparam logic [3:0] charger_irq_mask_offset        = 4'h6;
    localparam logic [3:0] system_voltage_offset          = 4'h7;
    localparam logic [3:0] charge_current_offset          = 4'h8;
    localparam logic [3:0] charge_control_offset          = 4'h9;

    // Threshold config field positions: hot, warm, cool, cold
    localparam int hot_lsb  = 0;
    localparam int warm_lsb = 2;
    localparam int cool_lsb = 4;
    localparam int cold_lsb = 6;

    // Thermistor config: enable bit and modified current field
    localparam int thermistor_enable_bit = 6;

    // Interrupt bits
    localparam int irq_temp_bit   = 0;
    localparam int irq_syscfg_bit = 1;
    localparam int irq_width      = 2;

    // Voltage code step is 25 mV; 200 mV margin is eight codes
    localparam int          cv_step_mv     = 25;
    localparam int          margin_mv      = 200;
    localparam logic [6:0]  margin_codes   = 7'(margin_mv / cv_step_mv);

    // Mux channel codes that need thermistor bias
    localparam logic [3:0] mux_sense_channel = 4'h9;
    localparam logic [3:0] mux_bias_channel  = 4'ha;

    // Reset values
    localparam logic [7:0] threshold_config_reset = 8'h00;
    localparam logic [5:0] cv_reset               = 6'h00;
    localparam logic [5:0] sysv_reset             = 6'h3f;

    // Temperature status encoding
    typedef enum logic [2:0]
    {
        ctz_zone_off    = 3'h0,
        ctz_zone_cold   = 3'h1,
        ctz_zone_cool   = 3'h2,
        ctz_zone_normal = 3'h3,
        ctz_zone_warm   = 3'h4,
        ctz_zone_hot    = 3'h5
    } ctz_zone_t;

endpackage

// ### rtl/ctz_zone_if.sv
// Interface carrying comparator levels and the decoded zone
`timescale 1ns/1ps
interface ctz_zone_if;
    logic               enable;
    logic [3:0]         cmp_raw;
    ctz_pkg::ctz_zone_t zone;

    modport decoder
    (
        input  enable,
        input  cmp_raw,
        output zone
    );
    modport user
    (
        output enable,
        output cmp_raw,
        input  zone
    );
endinterface

// ### rtl/ctz_zone_decode.sv
// Synchronises the four comparator levels and decodes the temperature zone
`timescale 1ns/1ps
module ctz_zone_decode
(
    // Clock and reset
    input  wire logic  clock,
    input  wire logic  arst_n,
    // Zone port
    ctz_zone_if.decoder zif
);

    // Bit order: 3 above hot, 2 above warm, 1 below cool, 0 below cold
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    ctz_pkg::ctz_zone_t zone_next;

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
        end
        else
        begin
            sync1_reg <= zif.cmp_raw; // R19
            sync2_reg <= sync1_reg;
        end
    end

    // Extremes take priority so a hot battery never reads merely warm
    always_comb
    begin
        if (!zif.enable)
            zone_next = ctz_pkg::ctz_zone_off;
        else if (sync2_reg[3])
            zone_next = ctz_pkg::ctz_zone_hot;
        else if (sync2_reg[0])
            zone_next = ctz_pkg::ctz_zone_cold;
        else if (sync2_reg[2])
            zone_next = ctz_pkg::ctz_zone_warm;
        else if (sync2_reg[1])
            zone_next = ctz_pkg::ctz_zone_cool;
        else
            zone_next = ctz_pkg::ctz_zone_normal;
    end

    assign zif.zone = zone_next; // R4 R18

endmodule

// ### rtl/ctz_cv_limit.sv
// Clamps a requested charge voltage code to stay the margin below the system rail
`timescale 1ns/1ps
module ctz_cv_limit
(
    // Request
    input  wire logic [5:0] cv_req,
    input  wire logic [5:0] sysv,
    // Result
    output logic      [5:0] cv_ok,
    output logic            too_high
);

    logic [6:0] ceiling;

    always_comb
    begin
        ceiling  = {1'b0, sysv} - ctz_pkg::margin_codes;
        too_high = 1'b0;
        cv_ok    = cv_req;
        // R1
        if ({1'b0, sysv} < ctz_pkg::margin_codes)
        begin
            too_high = 1'b1;
            cv_ok    = 6'h00;
        end
        else if ({1'b0, cv_req} > ceiling)
        begin
            too_high = 1'b1;
            cv_ok    = ceiling[5:0];
        end
    end

endmodule

// ### rtl/ctz_monitor.sv
// Charger temperature zone monitor and system voltage margin check
// Operation
// [R1] Lower charge voltage target while system voltage is under 200 mV above it.
// [R2] Rewrite charge voltage field with reduced value and flag configuration error.
// [R3] Software programs system voltage at least 200 mV above the target.
// [R4] With thermistor enabled, compare sense voltage against four thresholds continuously.
// [R5] Normal zone uses normal voltage and current, no modified state.
// [R6] Warm or cool zone uses the modified voltage and current fields.
// [R7] Modified settings live in registers independent of normal settings.
// [R8] Hot or cold zone pauses charging in the temperature fault state.
// [R9] Current zone is readable as a 3-bit status field.
// [R10] Any change of zone status sets a maskable interrupt flag.
// [R11] Thermistor disabled suppresses modified states and temperature fault.
// [R12] Each threshold has its own 2-bit selector of four trip voltages.
// [R13] Bias on while charger input valid and thermistor enabled.
// [R14] Bias on while mux selects sense or bias node.
// [R15] Mux selection never changes comparator results or temperature response.
// [R16] Fault exit returns to prior state; temperature fault outranks others.
// [R17] Timers pause in fault; prequal resumes, fast and top-off restart.
// [R18] Status encoding: off 0, cold 1, cool 2, normal 3, warm 4, hot 5.
// [R19] Comparator outputs are synchronised before zone decoding.
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
module ctz_monitor
(
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       arst_n,
    // Register port
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic      [7:0] reg_rdata,
    // Analog side
    input  wire logic [3:0] temp_cmp_in,
    input  wire logic       charger_input_valid,
    input  wire logic [3:0] analog_mux_sel,
    output logic [7:0]      threshold_sel_out,
    output logic            thermistor_bias_en,
    // Charge engine side
    input  wire logic       charger_other_fault,
    output logic [5:0]      active_charge_voltage,
    output logic [5:0]      active_charge_current,
    output logic            modified_state,
    output logic            temp_fault_state,
    output logic            timer_pause,
    output logic            fast_timers_restart,
    output logic            other_fault_hidden,
    // Interrupt
    output logic            charger_irq
);

    logic [7:0]               threshold_config_reg;
    logic                     thermistor_enable_reg;
    logic [5:0]               modified_charge_current_reg;
    logic [5:0]               charge_voltage_target_reg;
    logic [5:0]               modified_charge_voltage_reg;
    logic [5:0]               system_voltage_reg;
    logic [5:0]               charge_current_reg;
    logic [ctz_pkg::irq_width-1:0] irq_status_reg;
    logic [ctz_pkg::irq_width-1:0] irq_mask_reg;
    logic [2:0]               temp_zone_status_reg;
    logic [2:0]               zone_prev_reg;
    logic                     fault_prev_reg;
    logic [5:0]               cv_req;
    logic [5:0]               cv_fixed;
    logic                     cv_too_high;
    logic [ctz_pkg::irq_width-1:0] irq_set;
    logic [ctz_pkg::irq_width-1:0] irq_clr;
    logic                     zone_is_mod;
    logic                     zone_is_fault;

    ctz_zone_if zif ();

    // Mux select is deliberately not an input of the decoder
    assign zif.enable  = thermistor_enable_reg; // R11 R15
    assign zif.cmp_raw = temp_cmp_in;

    ctz_zone_decode u_decode
    (
        .clock  (clock),
        .arst_n (arst_n),
        .zif    (zif)
    );

    // Incoming CV write is checked before it lands
    assign cv_req = (reg_write && reg_addr == ctz_pkg::voltage_config_offset)
                    ? reg_wdata[5:0] : charge_voltage_target_reg;

    ctz_cv_limit u_cv_limit
    (
        .cv_req   (cv_req),
        .sysv     (system_voltage_reg),
        .cv_ok    (cv_fixed),
        .too_high (cv_too_high)
    );

    // Configuration registers
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            threshold_config_reg        <= ctz_pkg::threshold_config_reset;
            thermistor_enable_reg       <= 1'b0;
            modified_charge_current_reg <= 6'h00;
            modified_charge_voltage_reg <= ctz_pkg::cv_reset;
            system_voltage_reg          <= ctz_pkg::sysv_reset;
            charge_current_reg          <= 6'h00;
        end
        else if (reg_write)
        begin
            unique case (reg_addr)
                ctz_pkg::threshold_config_offset:
                    threshold_config_reg <= reg_wdata; // R12
                ctz_pkg::thermistor_config_offset:
                begin
                    thermistor_enable_reg       <= reg_wdata[ctz_pkg::thermistor_enable_bit];
                    modified_charge_current_reg <= reg_wdata[5:0]; // R7
                end
                ctz_pkg::modified_voltage_config_offset:
                    modified_charge_voltage_reg <= reg_wdata[5:0]; // R7
                ctz_pkg::system_voltage_offset:
                    system_voltage_reg <= reg_wdata[5:0];
                ctz_pkg::charge_current_offset:
                    charge_current_reg <= reg_wdata[5:0];
                default:
                    ;
            endcase
        end
    end

    // CV target loads the clamped value on every edge, so reads show the reduction
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            charge_voltage_target_reg <= ctz_pkg::cv_reset;
        else
            charge_voltage_target_reg <= cv_fixed; // R1 R2
    end

    // Zone status and change tracking
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            temp_zone_status_reg <= ctz_pkg::ctz_zone_off;
            zone_prev_reg        <= ctz_pkg::ctz_zone_off;
        end
        else
        begin
            temp_zone_status_reg <= zif.zone; // R9
            zone_prev_reg        <= temp_zone_status_reg;
        end
    end

    // Interrupts: set wins over write-one-to-clear
    assign irq_set[ctz_pkg::irq_temp_bit]   = temp_zone_status_reg != zone_prev_reg; // R10
    assign irq_set[ctz_pkg::irq_syscfg_bit] = cv_too_high; // R2
    assign irq_clr = (reg_write && reg_addr == ctz_pkg::charger_irq_offset)
                     ? reg_wdata[ctz_pkg::irq_width-1:0] : '0;

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irq_status_reg <= '0;
            irq_mask_reg   <= '0;
            charger_irq    <= 1'b0;
        end
        else
        begin
            irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_set;
            if (reg_write && reg_addr == ctz_pkg::charger_irq_mask_offset)
                irq_mask_reg <= reg_wdata[ctz_pkg::irq_width-1:0];
            charger_irq <= |(((irq_status_reg & ~irq_clr) | irq_set) & ~irq_mask_reg);
        end
    end

    // Zone classification feeding the charge engine
    assign zone_is_mod   = temp_zone_status_reg == ctz_pkg::ctz_zone_warm
                        || temp_zone_status_reg == ctz_pkg::ctz_zone_cool; // R6
    assign zone_is_fault = temp_zone_status_reg == ctz_pkg::ctz_zone_hot
                        || temp_zone_status_reg == ctz_pkg::ctz_zone_cold; // R8

    // Status ANDs each zone set with the enable, so a disabled monitor forces neither
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            modified_state        <= 1'b0;
            temp_fault_state      <= 1'b0;
            active_charge_voltage <= ctz_pkg::cv_reset;
            active_charge_current <= 6'h00;
            timer_pause           <= 1'b0;
            fast_timers_restart   <= 1'b0;
            other_fault_hidden    <= 1'b0;
            fault_prev_reg        <= 1'b0;
        end
        else
        begin
            modified_state   <= thermistor_enable_reg && zone_is_mod; // R5 R6 R11
            temp_fault_state <= thermistor_enable_reg && zone_is_fault; // R8 R11
            if (thermistor_enable_reg && zone_is_mod)
            begin
                active_charge_voltage <= modified_charge_voltage_reg; // R6
                active_charge_current <= modified_charge_current_reg;
            end
            else
            begin
                active_charge_voltage <= charge_voltage_target_reg; // R5
                active_charge_current <= charge_current_reg;
            end
            fault_prev_reg      <= temp_fault_state;
            // Charge engine holds its state while paused; on exit prequal resumes and fast_timers_restart restarts the fast timers
            timer_pause         <= thermistor_enable_reg && zone_is_fault; // R16 R17
            fast_timers_restart <= fault_prev_reg && !temp_fault_state; // R17
            other_fault_hidden  <= charger_other_fault && thermistor_enable_reg && zone_is_fault; // R16
        end
    end

    // Bias follows enable with a valid charger input, or a mux channel on the thermistor nodes
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            thermistor_bias_en <= 1'b0;
            threshold_sel_out  <= ctz_pkg::threshold_config_reset;
        end
        else
        begin
            thermistor_bias_en <= (charger_input_valid && thermistor_enable_reg) // R13
                               || analog_mux_sel == ctz_pkg::mux_sense_channel // R14
                               || analog_mux_sel == ctz_pkg::mux_bias_channel;
            threshold_sel_out  <= threshold_config_reg; // R12
        end
    end

    // Read data in the cycle after the strobe
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            reg_rdata <= 8'h00;
        else if (reg_read)
        begin
            unique case (reg_addr)
                ctz_pkg::threshold_config_offset:
                    reg_rdata <= threshold_config_reg;
                ctz_pkg::thermistor_config_offset:
                    reg_rdata <= {1'b0, thermistor_enable_reg, modified_charge_current_reg};
                ctz_pkg::voltage_config_offset:
                    reg_rdata <= {2'b00, charge_voltage_target_reg}; // R2
                ctz_pkg::modified_voltage_config_offset:
                    reg_rdata <= {2'b00, modified_charge_voltage_reg};
                ctz_pkg::charger_status_offset:
                    reg_rdata <= {5'h00, temp_zone_status_reg}; // R9
                ctz_pkg::charger_irq_offset:
                    reg_rdata <= {6'h00, irq_status_reg};
                ctz_pkg::charger_irq_mask_offset:
                    reg_rdata <= {6'h00, irq_mask_reg};
                ctz_pkg::system_voltage_offset:
                    reg_rdata <= {2'b00, system_voltage_reg};
                ctz_pkg::charge_current_offset:
                    reg_rdata <= {2'b00, charge_current_reg};
                default:
                    reg_rdata <= 8'h00;
            endcase
        end
        else
            reg_rdata <= 8'h00;
    end

    zone_change_a: assert property (@(posedge clock) disable iff (!arst_n)
        $changed(temp_zone_status_reg) |=> irq_status_reg[ctz_pkg::irq_temp_bit]) // R10
        else $error("zone change did not set flag");
    // A lowered system voltage is fixed on the following edge, so that cycle is skipped
    cv_margin_a: assert property (@(posedge clock) disable iff (!arst_n)
        $stable(system_voltage_reg) |-> ({1'b0, charge_voltage_target_reg} + ctz_pkg::margin_codes <= {1'b0, system_voltage_reg}
             || charge_voltage_target_reg == 6'h00)) // R1
        else $error("charge voltage margin violated");
    cv_flag_a: assert property (@(posedge clock) disable iff (!arst_n)
        cv_too_high |=> irq_status_reg[ctz_pkg::irq_syscfg_bit]) // R2
        else $error("config error flag missing");
    disabled_quiet_a: assert property (@(posedge clock) disable iff (!arst_n)
        !thermistor_enable_reg [*3] |=> !modified_state && !temp_fault_state) // R11
        else $error("temperature response while disabled");
    fault_zone_a: assert property (@(posedge clock) disable iff (!arst_n)
        (thermistor_enable_reg && zone_is_fault) |=> temp_fault_state && timer_pause) // R8
        else $error("fault zone not paused");
    normal_values_a: assert property (@(posedge clock) disable iff (!arst_n)
        (temp_zone_status_reg == ctz_pkg::ctz_zone_normal) |=> !modified_state
        && active_charge_voltage == $past(charge_voltage_target_reg)) // R5
        else $error("normal zone used modified values");
    bias_mux_a: assert property (@(posedge clock) disable iff (!arst_n)
        (analog_mux_sel == ctz_pkg::mux_bias_channel) |=> thermistor_bias_en) // R14
        else $error("bias off with mux on bias node");
    bias_enable_a: assert property (@(posedge clock) disable iff (!arst_n)
        (charger_input_valid && thermistor_enable_reg) |=> thermistor_bias_en) // R13
        else $error("bias off while enabled");
    restart_pulse_a: assert property (@(posedge clock) disable iff (!arst_n)
        $fell(temp_fault_state) |=> fast_timers_restart ##1 !fast_timers_restart) // R17
        else $error("restart pulse wrong");

    cover_warm_c: cover property (@(posedge clock) disable iff (!arst_n) $rose(modified_state));
    cover_fault_c: cover property (@(posedge clock) disable iff (!arst_n) $fell(temp_fault_state));
    cover_cvfix_c: cover property (@(posedge clock) disable iff (!arst_n) cv_too_high);
    cover_irq_c: cover property (@(posedge clock) disable iff (!arst_n) $rose(charger_irq));

endmodule

// ### verif/ctz_ntc_model.sv
// Behavioural battery thermistor with four comparator trips
`timescale 1ns/1ps
module ctz_ntc_model
#(
    parameter int cold_base = -10,
    parameter int cool_base = 0,
    parameter int warm_base = 35,
    parameter int hot_base  = 45,
    parameter int trip_step = 5
)
(
    // Clock
    input  wire logic              clock,
    // Bias and trip selection
    input  wire logic              bias_en,
    input  wire logic [7:0]        sel,
    input  wire logic signed [7:0] temp_c,
    // Comparator levels
    output logic [3:0]             cmp_out
);
    logic [3:0] live;
    logic [3:0] float_q = 4'h5;

    always_comb
    begin
        live[3] = int'(temp_c) > hot_base + trip_step * int'(sel[1:0]);
        live[2] = int'(temp_c) > warm_base + trip_step * int'(sel[3:2]);
        live[1] = int'(temp_c) < cool_base + trip_step * int'(sel[5:4]);
        live[0] = int'(temp_c) < cold_base + trip_step * int'(sel[7:6]);
    end

    // An unbiased divider floats, so the levels wander every cycle
    always_ff @(posedge clock)
    begin
        float_q <= ~float_q;
    end

    assign cmp_out = bias_en ? live : float_q;
endmodule

// ### verif/testbench.sv
// Self-checking testbench for the charger temperature zone monitor
`timescale 1ns/1ps
module testbench;
    logic              clock;
    logic              arst_n;
    logic [3:0]        reg_addr;
    logic [7:0]        reg_wdata;
    logic              reg_write;
    logic              reg_read;
    logic [7:0]        reg_rdata;
    logic [3:0]        temp_cmp_in;
    logic              charger_input_valid;
    logic [3:0]        analog_mux_sel;
    logic [7:0]        threshold_sel_out;
    logic              thermistor_bias_en;
    logic              charger_other_fault;
    logic [5:0]        active_charge_voltage;
    logic [5:0]        active_charge_current;
    logic              modified_state;
    logic              temp_fault_state;
    logic              timer_pause;
    logic              fast_timers_restart;
    logic              other_fault_hidden;
    logic              charger_irq;
    logic signed [7:0] temp_c;
    logic              masked;
    int                n_errors;
    int                cmp_count;
    ctz_pkg::ctz_zone_t prev_zone;

    ctz_monitor dut
    (
        .clock(clock), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .temp_cmp_in(temp_cmp_in), .charger_input_valid(charger_input_valid),
        .analog_mux_sel(analog_mux_sel), .threshold_sel_out(threshold_sel_out),
        .thermistor_bias_en(thermistor_bias_en), .charger_other_fault(charger_other_fault),
        .active_charge_voltage(active_charge_voltage), .active_charge_current(active_charge_current),
        .modified_state(modified_state), .temp_fault_state(temp_fault_state), .timer_pause(timer_pause),
        .fast_timers_restart(fast_timers_restart), .other_fault_hidden(other_fault_hidden),
        .charger_irq(charger_irq)
    );

    ctz_ntc_model ntc
    (
        .clock(clock), .bias_en(thermistor_bias_en), .sel(threshold_sel_out),
        .temp_c(temp_c), .cmp_out(temp_cmp_in)
    );

    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic summarize();
        if (n_errors == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        chk(reg_rdata, exp);
        @(posedge clock);
    endtask

    // Move the battery, let status settle, then check status, flags, restart pulses and irq, and the active values outside hot and cold
    task automatic zstep(input logic signed [7:0] t, input ctz_pkg::ctz_zone_t z);
        int  pulses;
        logic mod;
        logic flt;
        logic pflt;
        pulses = 0;
        mod    = (z == ctz_pkg::ctz_zone_warm) || (z == ctz_pkg::ctz_zone_cool);
        flt    = (z == ctz_pkg::ctz_zone_hot) || (z == ctz_pkg::ctz_zone_cold);
        pflt   = (prev_zone == ctz_pkg::ctz_zone_hot) || (prev_zone == ctz_pkg::ctz_zone_cold);
        temp_c <= t;
        repeat (8)
        begin
            @(posedge clock);
            #1;
            pulses += int'(fast_timers_restart);
        end
        // Back on the edge so the read strobe starts right after it
        @(posedge clock);
        rd(ctz_pkg::charger_status_offset, {5'h00, z});
        chk(8'(modified_state), 8'(mod));
        chk(8'(temp_fault_state), 8'(flt));
        chk(8'(timer_pause), 8'(flt));
        chk(8'(other_fault_hidden), 8'(flt & charger_other_fault));
        chk(8'(pulses), 8'(pflt && !flt));
        chk(8'(charger_irq), 8'((z != prev_zone) && !masked));
        if (!flt)
        begin
            chk(8'(active_charge_voltage), mod ? 8'h10 : 8'h16);
            chk(8'(active_charge_current), mod ? 8'h05 : 8'h2a);
        end
        wr(ctz_pkg::charger_irq_offset, 8'h01);
        prev_zone = z;
    endtask

    task automatic bias(input logic v, input logic en, input logic [3:0] m, input logic exp);
        charger_input_valid <= v;
        analog_mux_sel      <= m;
        wr(ctz_pkg::thermistor_config_offset, {1'b0, en, 6'h05});
        repeat (3) @(posedge clock);
        chk(8'(thermistor_bias_en), 8'(exp));
    endtask

    initial
    begin
        #100000;
        n_errors++;
        summarize();
    end

    initial
    begin
        arst_n = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        charger_input_valid = 1'b1;
        analog_mux_sel = 4'h0;
        charger_other_fault = 1'b0;
        temp_c = 8'sd25;
        masked = 1'b0;
        n_errors = 0;
        cmp_count = 0;
        prev_zone = ctz_pkg::ctz_zone_off;
        repeat (10) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        rd(ctz_pkg::threshold_config_offset, 8'h00);
        rd(ctz_pkg::thermistor_config_offset, 8'h00);
        rd(ctz_pkg::voltage_config_offset, 8'h00);
        rd(ctz_pkg::system_voltage_offset, 8'h3f);
        rd(ctz_pkg::charger_irq_mask_offset, 8'h00);
        wr(4'hf, 8'hff);
        rd(4'hf, 8'h00);
        // Deliberately break the margin to see the clamp
        wr(ctz_pkg::system_voltage_offset, 8'h20);
        wr(ctz_pkg::voltage_config_offset, 8'h1c);
        rd(ctz_pkg::voltage_config_offset, 8'h18);
        rd(ctz_pkg::charger_irq_offset, 8'h02);
        chk(8'(charger_irq), 8'h01);
        wr(ctz_pkg::charger_irq_offset, 8'h02);
        wr(ctz_pkg::voltage_config_offset, 8'h18);
        rd(ctz_pkg::charger_irq_offset, 8'h00);
        wr(ctz_pkg::system_voltage_offset, 8'h1e);
        rd(ctz_pkg::voltage_config_offset, 8'h16);
        rd(ctz_pkg::charger_irq_offset, 8'h02);
        wr(ctz_pkg::charger_irq_offset, 8'h02);
        wr(ctz_pkg::charge_current_offset, 8'h2a);
        wr(ctz_pkg::modified_voltage_config_offset, 8'h10);
        charger_other_fault <= 1'b1;
        analog_mux_sel <= ctz_pkg::mux_sense_channel;
        // Let the biased levels fill the synchroniser before monitoring starts
        repeat (3) @(posedge clock);
        wr(ctz_pkg::thermistor_config_offset, 8'h45);
        zstep(8'sd25, ctz_pkg::ctz_zone_normal);
        zstep(8'sd40, ctz_pkg::ctz_zone_warm);
        zstep(8'sd50, ctz_pkg::ctz_zone_hot);
        zstep(-8'sd5, ctz_pkg::ctz_zone_cool);
        zstep(-8'sd20, ctz_pkg::ctz_zone_cold);
        zstep(8'sd25, ctz_pkg::ctz_zone_normal);
        masked = 1'b1;
        wr(ctz_pkg::charger_irq_mask_offset, 8'h01);
        wr(ctz_pkg::threshold_config_offset, 8'h03);
        @(posedge clock);
        chk(threshold_sel_out, 8'h03);
        zstep(8'sd50, ctz_pkg::ctz_zone_warm);
        zstep(8'sd70, ctz_pkg::ctz_zone_hot);
        wr(ctz_pkg::thermistor_config_offset, 8'h05);
        zstep(8'sd70, ctz_pkg::ctz_zone_off);
        wr(ctz_pkg::thermistor_config_offset, 8'h45);
        repeat (8) @(posedge clock);
        chk(8'(charger_irq), 8'h00);
        wr(ctz_pkg::charger_irq_mask_offset, 8'h00);
        @(posedge clock);
        chk(8'(charger_irq), 8'h01);
        bias(1'b1, 1'b0, ctz_pkg::mux_sense_channel, 1'b1);
        bias(1'b0, 1'b0, ctz_pkg::mux_bias_channel, 1'b1);
        bias(1'b1, 1'b0, 4'h0, 1'b0);
        bias(1'b0, 1'b1, 4'h0, 1'b0);
        bias(1'b1, 1'b1, 4'h0, 1'b1);
        summarize();
    end
endmodule
